/* logic/drf_map.vh */
// timing and encoding constants for the refresh scheduler
`ifndef DRF_MAP_VH
`define DRF_MAP_VH
`define DRF_CLK_MHZ 125
`define DRF_TREFI_NS 7800
`define DRF_TRFC_NS 260
`define DRF_TRP_NS 14
`define DRF_MODE_1X 2'h0
`define DRF_MODE_2X 2'h1
`define DRF_MODE_4X 2'h2
`define DRF_LIM_1X 7'h08
`define DRF_LIM_2X 7'h10
`define DRF_LIM_4X 7'h20
`define DRF_WIN_1X 8'h10
`define DRF_WIN_2X 8'h20
`define DRF_WIN_4X 8'h40
`define DRF_HIST_AW 6
`endif

/* logic/drf_hist_mem.v */
// memory of recent refresh issue timestamps for the burst window check
`timescale 1ns/10ps
`default_nettype none
module drf_hist_mem #(
  parameter AW = 6,
  parameter DW = 24
) (
  input wire i_sys_clk, // system clock
  input wire i_we, // write strobe
  input wire [AW-1:0] i_waddr, // write address
  input wire [DW-1:0] i_wdata, // write data
  input wire [AW-1:0] i_raddr, // read address
  output reg [DW-1:0] o_rdata // registered read data
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];
  always @(posedge i_sys_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end
endmodule
`default_nettype wire

/* logic/drf_sched.v */
// refresh scheduler that drives refresh commands onto the command pins
`timescale 1ns/10ps
`default_nettype none
`include "drf_map.vh"
// Contract
// - refresh is cs, ras, cas low with we and act high at a clock edge.
// - issue one refresh per needed refresh, averaging one per refresh interval.
// - all banks precharged and idle for tRP before refresh.
// - only deselects until tRFC has elapsed after a refresh.
// - postponed refresh count never exceeds 8, 16 or 32 by mode.
// - gap between refreshes at most 9, 17 or 33 intervals by mode; the scheduler only raises o_urgent and waits for i_banks_idle.
// - up to 8, 16 or 32 refreshes may be pulled in, each crediting one.
// - pull-ins beyond the limit earn no credit.
// - at most 16, 32, 64 refreshes in 2, 4, 8 intervals by mode.
// - tRFC is a density dependent parameter.
module drf_sched #(
  parameter TREFI_NS = `DRF_TREFI_NS,
  parameter TRFC_NS = `DRF_TRFC_NS,
  parameter TRP_NS = `DRF_TRP_NS,
  parameter TREFI_CYC = (TREFI_NS * `DRF_CLK_MHZ) / 1000,
  parameter TRFC_CYC = (TRFC_NS * `DRF_CLK_MHZ + 999) / 1000,
  parameter TRP_CYC = (TRP_NS * `DRF_CLK_MHZ + 999) / 1000
) (
  input wire i_sys_clk, // system clock, 125 MHz
  input wire i_rst_b, // async reset, active low
  input wire [1:0] i_mode, // refresh mode 1x, 2x, 4x
  input wire i_banks_idle, // all banks precharged, from same-clock logic
  input wire i_pull_req, // request an early refresh while bus is free
  output wire o_cmd_own, // scheduler holds the command bus
  output reg o_cs_b, // chip select, active low
  output reg o_act_b, // activate, active low
  output reg o_ras_b, // ras/a16
  output reg o_cas_b, // cas/a15
  output reg o_we_b, // we/a14
  output reg o_addr_oe, // address bus enable, always low here
  output reg o_ref_pulse, // one cycle when refresh driven
  output wire o_blackout, // high during tRFC blackout
  output wire o_urgent, // debt at postpone limit
  output wire [6:0] o_debt // signed refresh debt
);
  localparam S_IDLE = 4'b0001;
  localparam S_WAIT = 4'b0010;
  localparam S_ISSUE = 4'b0100;
  localparam S_BLK = 4'b1000;
  localparam AW = `DRF_HIST_AW;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [15:0] ivl_cnt_r; // interval timer
  reg [15:0] rfc_cnt_r; // blackout counter
  reg [7:0] trp_cnt_r; // idle time counter
  reg signed [6:0] debt_r;
  reg [23:0] now_r; // free running cycle stamp
  reg [AW-1:0] wptr_r;
  reg [7:0] in_win_r; // refreshes logged in window
  wire [23:0] old_stamp;
  wire ivl_tick;
  wire [15:0] ivl_len;
  wire [6:0] lim;
  wire [7:0] win_max;
  wire [23:0] win_len;
  wire do_ref;
  wire win_ok;
  reg win_chg_r; // history read is stale this cycle
  wire retire;
  wire [AW-1:0] hist_raddr;
  wire ref_due;
  wire pull_ok;
  wire trp_met;

  function [6:0] mode_lim;
    input [1:0] m;
    begin
      if (m == `DRF_MODE_2X) begin
        mode_lim = `DRF_LIM_2X;
      end else if (m == `DRF_MODE_4X) begin
        mode_lim = `DRF_LIM_4X;
      end else begin
        mode_lim = `DRF_LIM_1X;
      end
    end
  endfunction

  function [7:0] mode_win;
    input [1:0] m;
    begin
      if (m == `DRF_MODE_2X) begin
        mode_win = `DRF_WIN_2X;
      end else if (m == `DRF_MODE_4X) begin
        mode_win = `DRF_WIN_4X;
      end else begin
        mode_win = `DRF_WIN_1X;
      end
    end
  endfunction

  // interval shrinks by 2 or 4 in finer modes
  function [15:0] mode_ivl;
    input [1:0] m;
    begin
      if (m == `DRF_MODE_2X) begin
        mode_ivl = TREFI_CYC[16:1];
      end else if (m == `DRF_MODE_4X) begin
        mode_ivl = TREFI_CYC[17:2];
      end else begin
        mode_ivl = TREFI_CYC[15:0];
      end
    end
  endfunction

  assign ivl_len = mode_ivl(i_mode);
  assign lim = mode_lim(i_mode);
  assign win_max = mode_win(i_mode);
  // window always spans 2 x tREFI of 1x time
  assign win_len = {7'h00, TREFI_CYC[15:0], 1'b0};
  // >= so that a shorter interval after a mode change cannot strand the timer
  assign ivl_tick = (ivl_cnt_r >= ivl_len - 16'h0001);
  assign o_debt = debt_r;
  assign o_urgent = (debt_r >= $signed(lim));
  assign o_blackout = (state_r == S_BLK);
  assign o_cmd_own = (state_r != S_IDLE);
  // window has room while fewer than win_max stored stamps are inside it
  assign win_ok = (in_win_r < win_max);
  assign do_ref = (state_r == S_ISSUE);

  // registered history read lags a pointer move by one cycle; skip retiring then
  assign retire = (in_win_r != 8'h00) && !win_chg_r && (now_r - old_stamp >= win_len);
  assign hist_raddr = wptr_r - in_win_r[AW-1:0];
  // at least one interval owed
  assign ref_due = (debt_r > 7'sh00);
  // pull-in allowed only while credit remains
  assign pull_ok = i_pull_req && (debt_r > -$signed(lim));
  // banks idle long enough for the precharge time
  assign trp_met = i_banks_idle && (trp_cnt_r >= TRP_CYC[7:0]);

  // ring of issue stamps; the oldest one still in the window is read back
  drf_hist_mem #(
    .AW(AW),
    .DW(24)
  ) u_hist (
    .i_sys_clk(i_sys_clk),
    .i_we(do_ref),
    .i_waddr(wptr_r),
    .i_wdata(now_r),
    .i_raddr(hist_raddr),
    .o_rdata(old_stamp)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        // owe refresh, or pull in while credit remains
        if (ref_due || pull_ok) begin
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (trp_met && win_ok) begin
          state_nxt = S_ISSUE;
        end
      end
      S_ISSUE: begin
        // refresh shows on the pins during the first blackout cycle
        state_nxt = S_BLK;
      end
      S_BLK: begin
        if (rfc_cnt_r == TRFC_CYC[15:0] - 16'h0001) begin
          state_nxt = S_IDLE; // banks idle again
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // state register
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // free running stamp for the burst window
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      now_r <= 24'h000000;
    end else begin
      now_r <= now_r + 24'h000001;
    end
  end

  // interval timer, one tick per refresh interval of the mode
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ivl_cnt_r <= 16'h0000;
    end else if (ivl_tick) begin
      ivl_cnt_r <= 16'h0000;
    end else begin
      ivl_cnt_r <= ivl_cnt_r + 16'h0001;
    end
  end

  // time the banks have been idle, saturating
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trp_cnt_r <= 8'h00;
    end else if (!i_banks_idle) begin
      trp_cnt_r <= 8'h00;
    end else if (trp_cnt_r != 8'hFF) begin
      trp_cnt_r <= trp_cnt_r + 8'h01;
    end
  end

  // blackout length counter
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rfc_cnt_r <= 16'h0000;
    end else if (state_r == S_BLK) begin
      rfc_cnt_r <= rfc_cnt_r + 16'h0001;
    end else begin
      rfc_cnt_r <= 16'h0000;
    end
  end

  // debt saturates at both limits; a tick and a refresh in one cycle cancel
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      debt_r <= 7'sh00;
    end else if (ivl_tick && !do_ref) begin
      if (debt_r < $signed(lim)) begin
        debt_r <= debt_r + 7'sh01;
      end
    end else if (do_ref && !ivl_tick) begin
      // surplus pull-ins earn no credit
      if (debt_r > -$signed(lim)) begin
        debt_r <= debt_r - 7'sh01;
      end
    end
  end

  // history write pointer
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wptr_r <= {AW{1'b0}};
    end else if (do_ref) begin
      wptr_r <= wptr_r + {{(AW-1){1'b0}}, 1'b1};
    end
  end

  // window count: log one stamp per refresh, retire the oldest once aged out
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_win_r <= 8'h00;
    end else if (do_ref && !retire) begin
      in_win_r <= in_win_r + 8'h01;
    end else if (!do_ref && retire) begin
      in_win_r <= in_win_r - 8'h01;
    end
  end

  // marks the cycle in which the history read still shows the old slot
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      win_chg_r <= 1'b0;
    end else begin
      win_chg_r <= do_ref || retire;
    end
  end

  // refresh strobe for the user side
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ref_pulse <= 1'b0;
    end else begin
      o_ref_pulse <= do_ref;
    end
  end

  // command pins: refresh encoding for one cycle, deselect otherwise
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cs_b <= 1'b1;
      o_act_b <= 1'b1;
      o_ras_b <= 1'b1;
      o_cas_b <= 1'b1;
      o_we_b <= 1'b1;
      o_addr_oe <= 1'b0;
    end else begin
      o_cs_b <= !do_ref;
      o_ras_b <= !do_ref;
      o_cas_b <= !do_ref;
      o_we_b <= 1'b1;
      o_act_b <= 1'b1;
      o_addr_oe <= 1'b0; // address left to the device counter
    end
  end
endmodule
`default_nettype wire

/* tb/drf_sched_sva.sv */
// assertions on the refresh scheduler pins
`timescale 1ns/10ps
`default_nettype none
module drf_sched_sva #(parameter TRFC_CYC = 33) (
  input wire logic i_sys_clk, input wire logic i_rst_b, input wire logic [1:0] i_mode,
  input wire logic i_banks_idle, input wire logic o_cs_b, input wire logic o_act_b,
  input wire logic o_ras_b, input wire logic o_cas_b, input wire logic o_we_b,
  input wire logic o_addr_oe, input wire logic o_ref_pulse, input wire logic o_blackout,
  input wire logic o_cmd_own, input wire logic o_urgent, input wire logic [6:0] o_debt);
  logic [7:0] gap_r;
  int lim;
  assign lim = (i_mode == 2'h1) ? 16 : (i_mode == 2'h2) ? 32 : 8;
  // cycles since the last refresh, saturating
  always @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b) gap_r <= 8'hFF;
    else if (o_ref_pulse) gap_r <= 8'h01;
    else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  AST_REF_CODE: assert property (
    o_ref_pulse |-> !o_cs_b && !o_ras_b && !o_cas_b && o_we_b && o_act_b) else $error("bad code");
  AST_CS_ONLY_REF: assert property (!o_cs_b |-> o_ref_pulse) else $error("stray select");
  AST_ADDR_FREE: assert property (!o_addr_oe) else $error("address driven");
  AST_TRP: assert property (
    o_ref_pulse |-> $past(i_banks_idle, 2)) else $error("banks not idle");
  AST_SPACING: assert property (
    o_ref_pulse |-> gap_r > TRFC_CYC) else $error("refresh too close");
  AST_BLK_LEN: assert property (
    $fell(o_blackout) |-> gap_r == TRFC_CYC) else $error("blackout length");
  AST_BLK_START: assert property (
    o_ref_pulse |-> o_blackout && o_cmd_own) else $error("no blackout");
  AST_DEBT_LIM: assert property (
    $signed(o_debt) <= lim && $signed(o_debt) >= -lim) else $error("debt out of range");
  AST_URGENT: assert property (
    o_urgent == ($signed(o_debt) >= lim)) else $error("urgent wrong");
  cover property (o_ref_pulse);
  cover property ($fell(o_blackout));
  cover property (o_urgent);
endmodule
`default_nettype wire

/* tb/drf_dev_model.sv */
// behavioural memory device watching refresh commands
`timescale 1ns/10ps
`default_nettype none
module drf_dev_model #(parameter TRFC_CYC = 33) (
  input wire logic i_clk, input wire logic i_rst_b, input wire logic i_cs_b,
  input wire logic i_act_b, input wire logic i_ras_b, input wire logic i_cas_b,
  input wire logic i_we_b, input wire logic i_open,
  output logic o_idle, output logic [15:0] o_refs, output logic o_viol);
  logic [7:0] blk_r;
  logic [14:0] row_r;
  logic [1:0] pre_r;
  wire ref_hit = !i_cs_b && i_act_b && !i_ras_b && !i_cas_b && i_we_b;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_idle <= 1'b1; o_refs <= 16'h0; o_viol <= 1'b0;
      blk_r <= 8'h0; row_r <= 15'h0; pre_r <= 2'h0;
    end else begin
      o_idle <= !i_open; // all banks precharged one cycle after i_open goes low
      if (!o_idle) pre_r <= 2'h0;
      else if (pre_r != 2'h3) pre_r <= pre_r + 2'h1;
      if (blk_r != 8'h0) blk_r <= blk_r - 8'h01;
      if (!i_cs_b && (blk_r != 8'h0 || !ref_hit)) o_viol <= 1'b1;
      if (ref_hit) begin
        o_refs <= o_refs + 16'h1;
        row_r <= row_r + 15'h1; // address bus ignored, row from own counter
        blk_r <= 8'(TRFC_CYC - 1);
        if (pre_r < 2'h2) o_viol <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/drf_sched_tb_top.sv */
// testbench for the refresh scheduler
`timescale 1ns/10ps
`default_nettype none
module drf_sched_tb_top;
  logic clk, rst_b, pull, open, idle, viol, cs_b, act_b, ras_b, cas_b, we_b, oe, pulse, blk;
  logic own, urg;
  logic [1:0] mode;
  logic [6:0] debt;
  logic [15:0] refs, r0;
  int failures, n_tests;
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  drf_sched #(.TREFI_CYC(100)) DUT (.i_sys_clk(clk), .i_rst_b(rst_b), .i_mode(mode),
    .i_banks_idle(idle), .i_pull_req(pull), .o_cmd_own(own), .o_cs_b(cs_b), .o_act_b(act_b),
    .o_ras_b(ras_b), .o_cas_b(cas_b), .o_we_b(we_b), .o_addr_oe(oe), .o_ref_pulse(pulse),
    .o_blackout(blk), .o_urgent(urg), .o_debt(debt));
  drf_dev_model MDL (.i_clk(clk), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_act_b(act_b),
    .i_ras_b(ras_b), .i_cas_b(cas_b), .i_we_b(we_b), .i_open(open), .o_idle(idle),
    .o_refs(refs), .o_viol(viol));
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task rst(input logic [1:0] m);
    rst_b = 0; mode = m; pull = 0; open = 0;
    cyc(5);
    rst_b = 1;
  endtask
  task t_steady;
    rst(2'h0);
    cyc(50);
    r0 = refs;
    cyc(1000);
    chk("refs", refs - r0, 16'h000A);
    chk("viol", viol, 16'h0);
  endtask
  task t_postpone(input logic [1:0] m, input logic [6:0] lim);
    rst(m);
    open = 1;
    cyc(1200);
    chk("held refs", refs, 16'h0);
    chk("debt", debt, lim);
    chk("urgent", urg, 16'h1);
    open = 0;
    r0 = refs;
    cyc(200);
    chk("catch up", refs - r0 > 16'h3, 16'h1);
    chk("viol", viol, 16'h0);
  endtask
  task t_pull;
    rst(2'h0);
    pull = 1;
    cyc(1200);
    chk("pulled refs", refs >= 16'h13 && refs <= 16'h14, 16'h1);
    chk("debt floor", $signed(debt) >= -8 && $signed(debt) <= -7, 16'h1);
  endtask
  task conclude;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    conclude;
  end
  initial begin
    failures = 0; n_tests = 0; rst_b = 0; mode = 2'h0; pull = 0; open = 0;
    t_steady;
    t_postpone(2'h0, 7'h08);
    t_postpone(2'h1, 7'h10);
    t_postpone(2'h2, 7'h20);
    t_pull;
    conclude;
  end
endmodule
bind drf_sched drf_sched_sva #(.TRFC_CYC(TRFC_CYC)) u_sva (.i_sys_clk(i_sys_clk),
  .i_rst_b(i_rst_b), .i_mode(i_mode), .i_banks_idle(i_banks_idle), .o_cs_b(o_cs_b),
  .o_act_b(o_act_b), .o_ras_b(o_ras_b), .o_cas_b(o_cas_b), .o_we_b(o_we_b),
  .o_addr_oe(o_addr_oe), .o_ref_pulse(o_ref_pulse), .o_blackout(o_blackout),
  .o_cmd_own(o_cmd_own), .o_urgent(o_urgent), .o_debt(o_debt));
`default_nettype wire
